// ===== hw/ecr_config_regs.sv
// Purpose: Non-volatile configuration register bank: calibration mode,
//          port disable, output framing, DAC offset, range and rate.
// Assumes: Access strobes come from one-wire port logic on clk;
//          the stored image is replayed byte by byte after reset.
// Notes:   Reserved bits ignore writes and read as zero.
`timescale 1ns/1ps
`default_nettype none
`include "ecr_map.svh"

module ecr_config_regs
	import ecr_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] cmdValue,
	input wire logic [7:0] portAddr,
	input wire logic [7:0] portWrData,
	input wire logic portWrStb,
	input wire logic portRdStb,
	output logic [7:0] portRdData,
	output logic portRdValid,
	input wire logic nvLoadStb,
	input wire logic [7:0] nvLoadAddr,
	input wire logic [7:0] nvLoadData,
	input wire logic nvLoadDone,
	input wire logic nvCrcErr,
	output logic loadEnd,
	output logic crcErrFlag,
	output logic lockForceClear,
	output logic portDisabled,
	output logic calMode,
	output logic [3:0] tickSelect,
	output logic pauseSuppress,
	output logic [2:0] frameLayout,
	output logic [6:0] capDacOffsetHalfPf,
	output logic [1:0] capRangeSelect,
	output logic [4:0] diffRangePf,
	output logic [5:0] cmRangePf,
	output ecr_rate_t primaryClass,
	output logic [2:0] primaryHalvings,
	output ecr_low_t primaryLowRate,
	output logic primaryNotch50,
	output logic primaryEnable
);

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	function automatic logic [`ECR_NUM_REGS-1:0] regHit(
		input logic [7:0] addr
	);
		regHit = '0;
		unique case (addr)
			`ECR_ADDR_SYS: regHit[`ECR_IDX_SYS] = 1'b1;
			`ECR_ADDR_OUT: regHit[`ECR_IDX_OUT] = 1'b1;
			`ECR_ADDR_CAP: regHit[`ECR_IDX_CAP] = 1'b1;
			`ECR_ADDR_PRI: regHit[`ECR_IDX_PRI] = 1'b1;
			default: regHit = '0;
		endcase
	endfunction : regHit

	// ------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------
	localparam logic [7:0] WR_MASK [`ECR_NUM_REGS] = '{
		`ECR_MASK_SYS, `ECR_MASK_OUT, `ECR_MASK_CAP, `ECR_MASK_PRI
	};

	logic [7:0] cfg_r [`ECR_NUM_REGS];
	logic [`ECR_NUM_REGS-1:0] hostHit;
	logic [`ECR_NUM_REGS-1:0] loadHit;
	logic hostWrOk;
	logic loadEnd_r;
	logic crcErrFlag_r;
	logic lockForceClear_r;
	logic portDisabled_r;

	// Host may only write in command mode and while the port is live
	assign hostWrOk = portWrStb && (cmdValue == `ECR_CMD_MODE)
		&& !portDisabled_r;
	assign hostHit = regHit(portAddr);
	assign loadHit = regHit(nvLoadAddr);

	genvar gi;
	generate
		for (gi = 0; gi < `ECR_NUM_REGS; gi++) begin : g_reg
			if (gi == `ECR_IDX_SYS) begin : g_sys
				// Image with a bad CRC must not leave the port shut
				always_ff @(posedge clk) begin
					if (sys_rst) begin
						cfg_r[gi] <= `ECR_RST_VAL;
					end else if (nvCrcErr) begin
						cfg_r[gi][`ECR_PORTDIS_BIT] <= 1'b0;
					end else if (nvLoadStb && loadHit[gi]) begin
						cfg_r[gi] <= nvLoadData & WR_MASK[gi];
					end else if (hostWrOk && hostHit[gi]) begin
						cfg_r[gi] <= portWrData & WR_MASK[gi];
					end
				end
			end else begin : g_plain
				always_ff @(posedge clk) begin
					if (sys_rst) begin
						cfg_r[gi] <= `ECR_RST_VAL;
					end else if (nvLoadStb && loadHit[gi]) begin
						cfg_r[gi] <= nvLoadData & WR_MASK[gi];
					end else if (hostWrOk && hostHit[gi]) begin
						cfg_r[gi] <= portWrData & WR_MASK[gi];
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	logic [7:0] portRdData_r;
	logic portRdValid_r;
	logic [7:0] rdMux;

	always_comb begin
		rdMux = `ECR_RST_VAL;
		for (int i = 0; i < `ECR_NUM_REGS; i++) begin
			if (hostHit[i]) begin
				rdMux = cfg_r[i];
			end
		end
	end

	// Unmapped addresses read as zero, still acknowledged
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			portRdData_r <= `ECR_RST_VAL;
			portRdValid_r <= 1'b0;
		end else begin
			portRdValid_r <= portRdStb && !portDisabled_r;
			if (portRdStb) begin
				portRdData_r <= rdMux;
			end
		end
	end

	// ------------------------------------------------------------------
	// Load status and port disable
	// ------------------------------------------------------------------

	// Error wins over the end marker arriving with it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			crcErrFlag_r <= 1'b0;
			lockForceClear_r <= 1'b0;
		end else if (nvCrcErr) begin
			crcErrFlag_r <= 1'b1;
			lockForceClear_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			loadEnd_r <= 1'b0;
		end else if (nvLoadDone) begin
			loadEnd_r <= 1'b1;
		end
	end

	// Taken once per reset, so later writes wait for the next reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			portDisabled_r <= 1'b0;
		end else if (nvCrcErr) begin
			portDisabled_r <= 1'b0;
		end else if (nvLoadDone && !loadEnd_r && !crcErrFlag_r) begin
			portDisabled_r <= cfg_r[`ECR_IDX_SYS][`ECR_PORTDIS_BIT];
		end
	end

	// ------------------------------------------------------------------
	// Range and rate decode
	// ------------------------------------------------------------------
	logic [1:0] rangeCode;
	logic [4:0] diffNxt;
	logic [5:0] cmNxt;
	ecr_rate_t classNxt;
	logic [2:0] halvNxt;
	ecr_low_t lowNxt;
	logic notchNxt;

	assign rangeCode = cfg_r[`ECR_IDX_PRI][`ECR_RANGE_MSB:`ECR_RANGE_LSB];

	always_comb begin
		unique case (rangeCode)
			2'h0: begin
				diffNxt = `ECR_DIFF_16;
				cmNxt = `ECR_CM_48;
			end
			2'h1: begin
				diffNxt = `ECR_DIFF_12;
				cmNxt = `ECR_CM_36;
			end
			2'h2: begin
				diffNxt = `ECR_DIFF_8;
				cmNxt = `ECR_CM_24;
			end
			2'h3: begin
				diffNxt = `ECR_DIFF_4;
				cmNxt = `ECR_CM_24;
			end
		endcase
	end

	ecr_rate_decode u_rate (
		.rateSel(cfg_r[`ECR_IDX_PRI][`ECR_RATE_MSB:`ECR_RATE_LSB]),
		.rateClass(classNxt),
		.halvings(halvNxt),
		.lowRate(lowNxt),
		.notch50(notchNxt)
	);

	// ------------------------------------------------------------------
	// Registered configuration outputs
	// ------------------------------------------------------------------
	logic calMode_r;
	logic [3:0] tickSelect_r;
	logic pauseSuppress_r;
	logic [2:0] frameLayout_r;
	logic [6:0] capOffset_r;
	logic [1:0] capRange_r;
	logic [4:0] diffRange_r;
	logic [5:0] cmRange_r;
	ecr_rate_t primaryClass_r;
	logic [2:0] halvings_r;
	ecr_low_t lowRate_r;
	logic notch50_r;
	logic primaryEnable_r;

	// One cycle behind the register image
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			calMode_r <= 1'b0;
			tickSelect_r <= '0;
			pauseSuppress_r <= 1'b0;
			frameLayout_r <= '0;
		end else begin
			calMode_r <= cfg_r[`ECR_IDX_SYS][`ECR_CALMODE_BIT];
			tickSelect_r <=
				cfg_r[`ECR_IDX_OUT][`ECR_TICK_MSB:`ECR_TICK_LSB];
			pauseSuppress_r <= cfg_r[`ECR_IDX_OUT][`ECR_PAUSE_BIT];
			frameLayout_r <=
				cfg_r[`ECR_IDX_OUT][`ECR_LAYOUT_MSB:`ECR_LAYOUT_LSB];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			capOffset_r <= '0;
			capRange_r <= '0;
			diffRange_r <= `ECR_DIFF_16;
			cmRange_r <= `ECR_CM_48;
		end else begin
			capOffset_r <=
				cfg_r[`ECR_IDX_CAP][`ECR_CAP_DAC_OFFSET_FIELD_MSB:`ECR_CAP_DAC_OFFSET_FIELD_LSB];
			capRange_r <= rangeCode;
			diffRange_r <= diffNxt;
			cmRange_r <= cmNxt;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			primaryClass_r <= ECR_RATE_HALVING;
			halvings_r <= '0;
			lowRate_r <= ECR_LOW_20HZ;
			notch50_r <= 1'b0;
			primaryEnable_r <= 1'b1;
		end else begin
			primaryClass_r <= classNxt;
			halvings_r <= halvNxt;
			lowRate_r <= lowNxt;
			notch50_r <= notchNxt;
			primaryEnable_r <= (classNxt != ECR_RATE_OFF);
		end
	end

	assign portRdData = portRdData_r;
	assign portRdValid = portRdValid_r;
	assign loadEnd = loadEnd_r;
	assign crcErrFlag = crcErrFlag_r;
	assign lockForceClear = lockForceClear_r;
	assign portDisabled = portDisabled_r;
	assign calMode = calMode_r;
	assign tickSelect = tickSelect_r;
	assign pauseSuppress = pauseSuppress_r;
	assign frameLayout = frameLayout_r;
	assign capDacOffsetHalfPf = capOffset_r;
	assign capRangeSelect = capRange_r;
	assign diffRangePf = diffRange_r;
	assign cmRangePf = cmRange_r;
	assign primaryClass = primaryClass_r;
	assign primaryHalvings = halvings_r;
	assign primaryLowRate = lowRate_r;
	assign primaryNotch50 = notch50_r;
	assign primaryEnable = primaryEnable_r;

endmodule : ecr_config_regs
`default_nettype wire

// ===== hw/ecr_map.svh
// Purpose: Addresses, field positions and reset values of the
//          non-volatile configuration register bank.
// Assumes: Byte-wide registers reached through the one-wire port.
// Notes:   Definitions only.
`ifndef ECR_MAP_SVH
`define ECR_MAP_SVH

// ------------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------------
`define ECR_ADDR_SYS 8'ha1
`define ECR_ADDR_OUT 8'ha2
`define ECR_ADDR_CAP 8'ha3
`define ECR_ADDR_PRI 8'ha4
`define ECR_NUM_REGS 4
`define ECR_IDX_SYS 0
`define ECR_IDX_OUT 1
`define ECR_IDX_CAP 2
`define ECR_IDX_PRI 3

// ------------------------------------------------------------------
// Writable bits and reset values
// ------------------------------------------------------------------
`define ECR_MASK_SYS 8'h82
`define ECR_MASK_OUT 8'hff
`define ECR_MASK_CAP 8'h7f
`define ECR_MASK_PRI 8'h3f
`define ECR_RST_VAL 8'h00
`define ECR_CMD_MODE 8'h00

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define ECR_CALMODE_BIT 7
`define ECR_PORTDIS_BIT 1
`define ECR_TICK_MSB 7
`define ECR_TICK_LSB 4
`define ECR_PAUSE_BIT 3
`define ECR_LAYOUT_MSB 2
`define ECR_LAYOUT_LSB 0
`define ECR_CAP_DAC_OFFSET_FIELD_MSB 6
`define ECR_CAP_DAC_OFFSET_FIELD_LSB 0
`define ECR_RANGE_MSB 5
`define ECR_RANGE_LSB 4
`define ECR_RATE_MSB 3
`define ECR_RATE_LSB 0

// ------------------------------------------------------------------
// Capacitance range figures in pF
// ------------------------------------------------------------------
`define ECR_DIFF_16 5'h10
`define ECR_DIFF_12 5'h0c
`define ECR_DIFF_8 5'h08
`define ECR_DIFF_4 5'h04
`define ECR_CM_48 6'h30
`define ECR_CM_36 6'h24
`define ECR_CM_24 6'h18

// ------------------------------------------------------------------
// Rate codes
// ------------------------------------------------------------------
`define ECR_RATE_NOTCH_BASE 4'h8
`define ECR_RATE_OFF_BASE 4'he

`endif

// ===== hw/ecr_pkg.sv
// Purpose: Types shared by the configuration register bank.
// Assumes: Nothing beyond the map header.
// Notes:   Types only; numbers live in ecr_map.svh.
package ecr_pkg;

	// Primary converter operating class
	typedef enum logic [1:0] {
		ECR_RATE_HALVING,
		ECR_RATE_NOTCHED,
		ECR_RATE_OFF
	} ecr_rate_t;

	// Low-rate choice with mains notch
	typedef enum logic [1:0] {
		ECR_LOW_20HZ,
		ECR_LOW_10HZ,
		ECR_LOW_5HZ
	} ecr_low_t;

endpackage : ecr_pkg

// ===== hw/ecr_rate_decode.sv
// Purpose: Decode of the primary converter rate select field.
// Assumes: Combinational; caller registers the results.
// Notes:   Halving count is valid only in the halving class.
`timescale 1ns/1ps
`default_nettype none
`include "ecr_map.svh"

module ecr_rate_decode
	import ecr_pkg::*;
(
	input wire logic [3:0] rateSel,
	output ecr_rate_t rateClass,
	output logic [2:0] halvings,
	output ecr_low_t lowRate,
	output logic notch50
);

	logic [3:0] notchOff;

	always_comb begin
		notchOff = rateSel - `ECR_RATE_NOTCH_BASE;
		halvings = 3'h0;
		lowRate = ECR_LOW_20HZ;
		notch50 = 1'b0;
		if (rateSel >= `ECR_RATE_OFF_BASE) begin
			rateClass = ECR_RATE_OFF;
		end else if (rateSel >= `ECR_RATE_NOTCH_BASE) begin
			rateClass = ECR_RATE_NOTCHED;
			notch50 = rateSel[0];
			unique case (notchOff[2:1])
				2'h0: lowRate = ECR_LOW_20HZ;
				2'h1: lowRate = ECR_LOW_10HZ;
				default: lowRate = ECR_LOW_5HZ;
			endcase
		end else begin
			rateClass = ECR_RATE_HALVING;
			halvings = rateSel[2:0];
		end
	end

endmodule : ecr_rate_decode
`default_nettype wire

// ===== testbench/ecr_config_regs_assertions.sv
// Purpose: Port-level checks of the configuration register bank.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Bound to ecr_config_regs below.
`timescale 1ns/1ps
`default_nettype none
module ecr_config_regs_assertions
	import ecr_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] cmdValue,
	input wire logic [7:0] portAddr,
	input wire logic [7:0] portWrData,
	input wire logic portWrStb,
	input wire logic portRdStb,
	input wire logic portRdValid,
	input wire logic nvLoadStb,
	input wire logic nvLoadDone,
	input wire logic nvCrcErr,
	input wire logic loadEnd,
	input wire logic crcErrFlag,
	input wire logic lockForceClear,
	input wire logic portDisabled,
	input wire logic [1:0] capRangeSelect,
	input wire logic [4:0] diffRangePf,
	input wire logic [5:0] cmRangePf,
	input wire ecr_rate_t primaryClass,
	input wire logic primaryEnable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Accepted host write to the primary channel register
	sequence s_wrPri;
		portWrStb && cmdValue == 8'h00 && !portDisabled &&
			portAddr == 8'ha4 && !nvLoadStb;
	endsequence
	a_read_refused: assert property (portRdStb && portDisabled |=> !portRdValid)
		else $error("read answered while port off");
	a_load_end: assert property (nvLoadDone |=> loadEnd)
		else $error("load end flag missing");
	a_range_wide: assert property (capRangeSelect == 2'b00 |-> diffRangePf == 5'h10 && cmRangePf == 6'h30)
		else $error("wide range decode wrong");
	a_range_narrow: assert property (capRangeSelect == 2'b11 |-> diffRangePf == 5'h04 && cmRangePf == 6'h18)
		else $error("narrow range decode wrong");
	a_wr_range: assert property (s_wrPri |-> ##2 capRangeSelect == $past(portWrData[5:4], 2))
		else $error("range write not applied");
	a_wr_enable: assert property (s_wrPri |-> ##2 primaryEnable == ($past(portWrData[3:1], 2) != 3'b111))
		else $error("converter enable wrong");
	a_off_class: assert property (primaryEnable != (primaryClass == ECR_RATE_OFF))
		else $error("enable and class disagree");
	a_crc_forces: assert property (nvCrcErr |=> crcErrFlag && lockForceClear && !portDisabled)
		else $error("crc error not handled");
	a_crc_sticky: assert property (crcErrFlag |=> crcErrFlag && !portDisabled)
		else $error("crc flag lost or port off");
endmodule : ecr_config_regs_assertions
bind ecr_config_regs ecr_config_regs_assertions i_chk (.clk, .sys_rst,
	.cmdValue, .portAddr, .portWrData, .portWrStb, .portRdStb, .portRdValid,
	.nvLoadStb, .nvLoadDone, .nvCrcErr, .loadEnd, .crcErrFlag,
	.lockForceClear, .portDisabled, .capRangeSelect, .diffRangePf,
	.cmRangePf, .primaryClass, .primaryEnable);
`default_nettype wire

// ===== testbench/ecr_host_model.sv
// Purpose: One-wire host side: single byte reads and writes.
// Assumes: Drives at the falling edge, one strobe cycle each.
// Notes: Released lines show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module ecr_host_model (
	input wire logic clk,
	output logic [7:0] cmdValue,
	output logic [7:0] portAddr,
	output logic [7:0] portWrData,
	output logic portWrStb,
	output logic portRdStb
);
	initial begin
		cmdValue = 8'h03;
		portAddr = 8'h00;
		portWrData = 8'h00;
		portWrStb = 1'b0;
		portRdStb = 1'b0;
	end
	// Command value is set a cycle ahead; non-zero only to provoke refusal
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] c);
		@(negedge clk);
		cmdValue = c;
		@(negedge clk);
		portAddr = a;
		portWrData = d;
		portWrStb = 1'b1;
		@(negedge clk);
		portWrStb = 1'b0;
		portAddr = ~a;
		portWrData = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		portAddr = a;
		portRdStb = 1'b1;
		@(negedge clk);
		portRdStb = 1'b0;
		portAddr = ~a;
	endtask : rd
endmodule : ecr_host_model
`default_nettype wire

// ===== testbench/eeprom_config_registers_tb.sv
// Purpose: Self-checking bench of the configuration register bank.
// Assumes: Host model drives the port; bench replays the stored image.
// Notes: Reads are checked from a queue of expected bytes.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin testsRun++; if ((e) !== (g)) begin \
	errTotal++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module eeprom_config_registers_tb;
	import ecr_pkg::*;
	logic clk, sys_rst, portWrStb, portRdStb, portRdValid, nvLoadStb;
	logic nvLoadDone, nvCrcErr, loadEnd, crcErrFlag, lockForceClear;
	logic portDisabled, calMode, pauseSuppress, primaryNotch50;
	logic primaryEnable;
	logic [7:0] cmdValue, portAddr, portWrData, portRdData, nvLoadAddr;
	logic [7:0] nvLoadData, d, expB;
	logic [3:0] tickSelect;
	logic [2:0] frameLayout, primaryHalvings;
	logic [6:0] capDacOffsetHalfPf;
	logic [1:0] capRangeSelect;
	logic [4:0] diffRangePf;
	logic [5:0] cmRangePf;
	ecr_rate_t primaryClass;
	ecr_low_t primaryLowRate;
	logic [7:0] expQ[$];
	logic [7:0] ex[4];
	logic [7:0] msk[4] = '{8'h82, 8'hff, 8'h7f, 8'h3f};
	logic [4:0] dt[4] = '{5'h10, 5'h0c, 5'h08, 5'h04};
	logic [5:0] ct[4] = '{6'h30, 6'h24, 6'h18, 6'h18};
	logic [31:0] seed = 32'h1080b228;
	int errTotal = 0, testsRun = 0, cycles = 0, i;
	ecr_config_regs i_dut (.clk, .sys_rst, .cmdValue, .portAddr, .portWrData,
		.portWrStb, .portRdStb, .portRdData, .portRdValid, .nvLoadStb,
		.nvLoadAddr, .nvLoadData, .nvLoadDone, .nvCrcErr, .loadEnd,
		.crcErrFlag, .lockForceClear, .portDisabled, .calMode, .tickSelect,
		.pauseSuppress, .frameLayout, .capDacOffsetHalfPf, .capRangeSelect,
		.diffRangePf, .cmRangePf, .primaryClass, .primaryHalvings,
		.primaryLowRate, .primaryNotch50, .primaryEnable);
	ecr_host_model i_host (.clk, .cmdValue, .portAddr, .portWrData,
		.portWrStb, .portRdStb);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic summarize();
		$display("checks %0d mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	task automatic rst();
		@(negedge clk);
		sys_rst = 1'b1;
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
	endtask : rst
	task automatic nv(input logic [2:0] s, input logic [7:0] a,
		input logic [7:0] dat);
		@(negedge clk);
		{nvLoadStb, nvLoadDone, nvCrcErr} = s;
		nvLoadAddr = a;
		nvLoadData = dat;
		@(negedge clk);
		{nvLoadStb, nvLoadDone, nvCrcErr} = 3'b000;
		nvLoadAddr = ~a;
		nvLoadData = ~dat;
	endtask : nv
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errTotal++;
			summarize();
		end
	end
	// Reads answer one cycle late; settled by the falling edge
	always @(negedge clk) begin
		if (portRdValid === 1'b1) begin
			if (expQ.size() == 0) begin
				`CHK("unasked read", 1'b0, 1'b1)
			end else begin
				expB = expQ.pop_front();
				`CHK("read data", expB, portRdData)
			end
		end
	end
	initial begin
		sys_rst = 1'b1;
		nvLoadStb = 1'b0;
		nvLoadDone = 1'b0;
		nvCrcErr = 1'b0;
		nvLoadAddr = 8'h00;
		nvLoadData = 8'h00;
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
		`CHK("cal mode", 1'b0, calMode)
		`CHK("halvings", 3'h0, primaryHalvings)
		`CHK("offset", 7'h00, capDacOffsetHalfPf)
		for (i = 0; i < 5; i++) begin
			expQ.push_back(8'h00);
			i_host.rd(8'ha1 + 8'(i));
		end
		$display("test done: reset values");
		for (i = 0; i < 4; i++) begin
			seed = xs(seed);
			d = seed[7:0] | ((i == 0) ? 8'h02 : 8'h00);
			ex[i] = d & msk[i];
			i_host.wr(8'ha1 + 8'(i), d, 8'h00);
		end
		for (i = 0; i < 4; i++) begin
			expQ.push_back(ex[i]);
			i_host.rd(8'ha1 + 8'(i));
		end
		`CHK("cal mode", ex[0][7], calMode)
		`CHK("port off", 1'b0, portDisabled)
		`CHK("fields", ex[1], {tickSelect, pauseSuppress, frameLayout})
		`CHK("offset", ex[2][6:0], capDacOffsetHalfPf)
		$display("test done: write and read back");
		for (i = 0; i < 16; i++) begin
			seed = xs(seed);
			d = {seed[7:6], 2'(i), 4'(i)};
			i_host.wr(8'ha4, d, 8'h00);
			repeat (2) @(negedge clk);
			`CHK("range", d[5:4], capRangeSelect)
			`CHK("class", (i < 8) ? ECR_RATE_HALVING : (i < 14) ? ECR_RATE_NOTCHED : ECR_RATE_OFF, primaryClass)
			`CHK("diff", dt[d[5:4]], diffRangePf)
			`CHK("common", ct[d[5:4]], cmRangePf)
			`CHK("enable", 1'(i < 14), primaryEnable)
			`CHK("halvings", (i < 8) ? 3'(i) : 3'h0, primaryHalvings)
			`CHK("notch", 1'(i >= 8 && i < 14 && i % 2 == 1), primaryNotch50)
			`CHK("low", (i >= 8 && i < 14) ? 2'((i - 8) / 2) : 2'h0, 2'(primaryLowRate))
		end
		ex[3] = d & 8'h3f;
		$display("test done: rate and range sweep");
		i_host.wr(8'ha4, ~ex[3], 8'h03);
		i_host.wr(8'ha9, 8'h55, 8'h00);
		expQ.push_back(ex[3]);
		i_host.rd(8'ha4);
		expQ.push_back(8'h00);
		i_host.rd(8'ha9);
		$display("test done: refused writes");
		rst();
		nv(3'b100, 8'ha1, 8'h02);
		seed = xs(seed);
		d = seed[7:0];
		nv(3'b100, 8'ha3, d);
		nv(3'b010, 8'ha1, 8'h00);
		`CHK("loaded offset", d[6:0], capDacOffsetHalfPf)
		`CHK("load end", 1'b1, loadEnd)
		`CHK("port off", 1'b1, portDisabled)
		// No answer may come back while the port is off
		i_host.rd(8'ha1);
		repeat (3) @(negedge clk);
		$display("test done: port disable");
		rst();
		nv(3'b100, 8'ha1, 8'h82);
		nv(3'b001, 8'ha1, 8'h00);
		nv(3'b010, 8'ha1, 8'h00);
		`CHK("crc flag", 1'b1, crcErrFlag)
		`CHK("lock clear", 1'b1, lockForceClear)
		`CHK("port off", 1'b0, portDisabled)
		expQ.push_back(8'h80);
		i_host.rd(8'ha1);
		repeat (3) @(negedge clk);
		$display("test done: crc error");
		summarize();
	end
endmodule : eeprom_config_registers_tb
`default_nettype wire
